// ===== bqt_defines.svh
`ifndef BQT_DEFINES_SVH
`define BQT_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define BQT_ADR_CTRL      8'h00
`define BQT_ADR_THR_LOG   8'h04
`define BQT_ADR_THR_SQI   8'h08
`define BQT_ADR_THR_CLUTTER_CORRECTION  8'h0c
`define BQT_ADR_THR_SIG   8'h10
`define BQT_ADR_SQI2      8'h14
`define BQT_ADR_COMB0     8'h18
`define BQT_ADR_COMB_LAST 8'h28
`define BQT_ADR_STATUS    8'h2c
`define BQT_ADR_METRIC    8'h30
`define BQT_ADR_SNR       8'h34

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define BQT_CTRL_THREE    0
`define BQT_CTRL_EN_LSB   1
`define BQT_CTRL_RST      5'h1e
`define BQT_THR_LOG_RST   16'h0080
`define BQT_THR_SQI_RST   8'h80
`define BQT_THR_CLUTTER_CORRECTION_RST  16'he700
`define BQT_THR_SIG_RST   16'h0a00
`define BQT_SQI2_RST      16'hc0f0
`define BQT_COMB_ZC_RST   16'ha0a0
`define BQT_COMB_ZU_RST   16'haaaa
`define BQT_COMB_VEL_RST  16'hc0c0
`define BQT_COMB_WID_RST  16'hc000
`define BQT_COMB_ZDR_RST  16'haaaa
`define BQT_MARKER        16'h0000

// ---------------------------------------------------------------
// Arithmetic constants, 8 fraction bits
// ---------------------------------------------------------------
`define BQT_DB_PER_OCT    12'h303
`define BQT_WSQ_COEF      12'h71f
`define BQT_LOG2_2PI      12'h2a7

`endif

// ===== bqt_exp2.sv
`timescale 1ns/1ps
// Registered 2^y with 8 fraction bits; saturates at all ones
module bqt_exp2 #(
   parameter int W  = 24,
   parameter int LW = $clog2(W) + 8
) (
   input  wire logic          clk_i,
   input  wire logic [LW:0]   y_i,
   output logic      [W-1:0]  x_o
);
   logic [LW-8:0]  int_w;
   logic [W+7:0]   wide_w;
   logic           sat_w;

   assign int_w  = y_i[LW:8];
   assign sat_w  = int_w > (LW-7)'(W-1);
   assign wide_w = (W+8)'({1'b1, y_i[7:0]}) << int_w;

   always_ff @(posedge clk_i) begin
      x_o <= sat_w ? '1 : wide_w[W+7:8];
   end
endmodule : bqt_exp2

// ===== bqt_log2.sv
`timescale 1ns/1ps
// Registered log2 with 8 fraction bits; zero input gives zero
module bqt_log2 #(
   parameter int W  = 24,
   parameter int LW = $clog2(W) + 8
) (
   input  wire logic          clk_i,
   input  wire logic [W-1:0]  x_i,
   output logic      [LW-1:0] y_o
);
   function automatic logic [LW-9:0] msb_of(input logic [W-1:0] x);
      logic [LW-9:0] p;
      p = '0;
      for (int i = 0; i < W; i++) begin
         if (x[i]) begin
            p = (LW-8)'(i);
         end
      end
      return p;
   endfunction : msb_of

   logic [LW-9:0] msb_w;
   logic [W-1:0]  norm_w;

   assign msb_w  = msb_of(x_i);
   assign norm_w = x_i << ((LW-8)'(W-1) - msb_w);

   // Linear mantissa: error under 0.09 octave, traded for no table
   always_ff @(posedge clk_i) begin
      y_o <= {msb_w, norm_w[W-2 -: 8]};
   end

   if (W < 9) begin : g_chk
      $error("bqt_log2: W must be at least 9");
   end
endmodule : bqt_log2

// ===== bqt_pkg.sv
package bqt_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOG  = 3'h1,
      ST_EXP  = 3'h2,
      ST_LOG2 = 3'h3,
      ST_DB   = 3'h4,
      ST_DEC  = 3'h5,
      ST_OUT  = 3'h6
   } bqt_state_type;
endpackage : bqt_pkg

// ===== bqt_qualifier.sv
`timescale 1ns/1ps
`include "bqt_defines.svh"
// Contract
// - Clutter from filtered versus unfiltered power
// - Correction is 10log weather over clutter-plus-weather
// - Two-lag correction is 10log lag0 over total
// - Three-lag clutter is total minus lag0
// - Weather power from lag1 and width
// - Three-lag correction 10log one over ratio-plus-one
// - Two-lag weather ratio is SNR plus correction
// - Three-lag weather ratio from 2 pi S
// - Total SNR from total power and noise
// - Four tests pass on strictly greater
// - Each test enabled with own threshold
// - Tests combine by any AND/OR arrangement
// - SNR threshold defaults to 0.5 dB
// - Coherence threshold 0..1, default 0.5
// - Correction threshold -25 dB, at-or-below rejects
// - Weather ratio threshold defaults to 10 dB
// - Default combinations per output parameter
// - Reflectivity uses secondary coherence threshold
// - Secondary threshold applies in every mode
// - Coherence is lag1 magnitude over lag0
// - Width input is normalised spectrum width
module bqt_qualifier
   import bqt_pkg::*;
#(
   parameter int PW = 24
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          in_valid_i,
   output logic               in_ready_o,
   input  wire logic [PW-1:0] unfiltered_total_power_i,
   input  wire logic [PW-1:0] lag_zero_power_i,
   input  wire logic [PW-1:0] lag_one_autocorr_i,
   input  wire logic [PW-1:0] noise_power_i,
   input  wire logic [7:0]    spectrum_width_i,
   input  wire logic [15:0]   corrected_reflectivity_i,
   input  wire logic [15:0]   uncorrected_reflectivity_i,
   input  wire logic [15:0]   velocity_i,
   input  wire logic [15:0]   width_value_i,
   input  wire logic [15:0]   differential_reflectivity_i,
   output logic               out_valid_o,
   input  wire logic          out_ready_i,
   output logic [15:0]        corrected_reflectivity_o,
   output logic [15:0]        uncorrected_reflectivity_o,
   output logic [15:0]        velocity_o,
   output logic [15:0]        width_value_o,
   output logic [15:0]        differential_reflectivity_o,
   output logic [4:0]         out_pass_o
);
   localparam int LW = $clog2(PW) + 8;

   if (PW < 9 || PW > 30) begin : g_chk
      $error("bqt_qualifier: PW must be 9 to 30");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (n & m);
   endfunction : merge

   // Octave difference to dB in Q8.8
   function automatic logic [15:0] to_db(input logic signed [LW:0] d);
      logic signed [LW+12:0] p;
      p = (LW+13)'(d) * $signed({1'b0, `BQT_DB_PER_OCT});
      return p[23:8];
   endfunction : to_db

   function automatic logic [LW:0] ldiff(input logic [LW-1:0] a,
                                         input logic [LW-1:0] b);
      return {1'b0, a} - {1'b0, b};
   endfunction : ldiff

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   logic [4:0]    ctrl_q;
   logic [15:0]   thr_log_q, thr_clutter_correction_q, thr_sig_q, sqi2_q;
   logic [7:0]    thr_sqi_q;
   logic [15:0]   comb_q [5];
   logic          ack_q;
   logic [31:0]   dat_q;
   logic [15:0]   bin_cnt_q;
   logic [4:0]    pass_q;
   logic [15:0]   snr_q, clutter_correction_q, sig_q, ccor2_q;
   bqt_state_type state_q, state_d;

   wire [7:0]  adr      = {wb_adr_i[7:2], 2'b00};
   wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire        wr       = req & wb_we_i;
   wire        comb_hit = adr >= `BQT_ADR_COMB0 &&
                          adr <= `BQT_ADR_COMB_LAST;
   wire [7:0]  comb_off = adr - `BQT_ADR_COMB0;
   wire [2:0]  comb_idx = comb_off[4:2];
   wire        busy     = state_q != ST_IDLE;
   wire [31:0] rd_w =
      adr == `BQT_ADR_CTRL     ? {27'h0, ctrl_q} :
      adr == `BQT_ADR_THR_LOG  ? {16'h0, thr_log_q} :
      adr == `BQT_ADR_THR_SQI  ? {24'h0, thr_sqi_q} :
      adr == `BQT_ADR_THR_CLUTTER_CORRECTION ? {16'h0, thr_clutter_correction_q} :
      adr == `BQT_ADR_THR_SIG  ? {16'h0, thr_sig_q} :
      adr == `BQT_ADR_SQI2     ? {16'h0, sqi2_q} :
      comb_hit                 ? {16'h0, comb_q[comb_idx]} :
      adr == `BQT_ADR_STATUS   ? {busy, 10'h0, pass_q, bin_cnt_q} :
      adr == `BQT_ADR_METRIC   ? {sig_q, clutter_correction_q} :
      adr == `BQT_ADR_SNR      ? {16'h0, snr_q} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req;
         dat_q <= (req & ~wb_we_i) ? rd_w : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= `BQT_CTRL_RST;
         thr_log_q  <= `BQT_THR_LOG_RST;
         thr_sqi_q  <= `BQT_THR_SQI_RST;
         thr_clutter_correction_q <= `BQT_THR_CLUTTER_CORRECTION_RST;
         thr_sig_q  <= `BQT_THR_SIG_RST;
         sqi2_q     <= `BQT_SQI2_RST;
         comb_q[0]  <= `BQT_COMB_ZC_RST;
         comb_q[1]  <= `BQT_COMB_ZU_RST;
         comb_q[2]  <= `BQT_COMB_VEL_RST;
         comb_q[3]  <= `BQT_COMB_WID_RST;
         comb_q[4]  <= `BQT_COMB_ZDR_RST;
      end else if (wr) begin
         if (adr == `BQT_ADR_CTRL)
            ctrl_q <= 5'(merge({27'h0, ctrl_q}, wb_dat_i, wb_sel_i));
         if (adr == `BQT_ADR_THR_LOG)
            thr_log_q <= 16'(merge({16'h0, thr_log_q}, wb_dat_i,
                                   wb_sel_i));
         if (adr == `BQT_ADR_THR_SQI)
            thr_sqi_q <= 8'(merge({24'h0, thr_sqi_q}, wb_dat_i,
                                  wb_sel_i));
         if (adr == `BQT_ADR_THR_CLUTTER_CORRECTION)
            thr_clutter_correction_q <= 16'(merge({16'h0, thr_clutter_correction_q}, wb_dat_i,
                                    wb_sel_i));
         if (adr == `BQT_ADR_THR_SIG)
            thr_sig_q <= 16'(merge({16'h0, thr_sig_q}, wb_dat_i,
                                   wb_sel_i));
         if (adr == `BQT_ADR_SQI2)
            sqi2_q <= 16'(merge({16'h0, sqi2_q}, wb_dat_i, wb_sel_i));
         if (comb_hit)
            comb_q[comb_idx] <= 16'(merge({16'h0, comb_q[comb_idx]},
                                          wb_dat_i, wb_sel_i));
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   logic          ready_q, ovalid_q;
   wire           acc = in_valid_i & ready_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (acc) state_d = ST_LOG;
         ST_LOG:  state_d = ST_EXP;
         ST_EXP:  state_d = ST_LOG2;
         ST_LOG2: state_d = ST_DB;
         ST_DB:   state_d = ST_DEC;
         ST_DEC:  state_d = ST_OUT;
         ST_OUT:  if (out_ready_i) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q  <= ST_IDLE;
         ready_q  <= 1'b0;
         ovalid_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         ready_q  <= state_d == ST_IDLE;
         ovalid_q <= state_d == ST_OUT;
      end
   end

   // ------------------------------------------------------------
   // Bin capture
   // ------------------------------------------------------------
   logic [PW-1:0] t0_q, r0_q, r1_q, nz_q;
   logic [7:0]    w_q;
   logic [15:0]   val_q [5];

   always_ff @(posedge clk_i) begin
      if (acc) begin
         t0_q     <= unfiltered_total_power_i;
         r0_q     <= lag_zero_power_i;
         r1_q     <= lag_one_autocorr_i;
         nz_q     <= noise_power_i;
         w_q      <= spectrum_width_i;
         val_q[0] <= corrected_reflectivity_i;
         val_q[1] <= uncorrected_reflectivity_i;
         val_q[2] <= velocity_i;
         val_q[3] <= width_value_i;
         val_q[4] <= differential_reflectivity_i;
      end
   end

   // ------------------------------------------------------------
   // Log units, shared by both passes except unit 4; antilog units between the passes
   // ------------------------------------------------------------
   logic [PW-1:0] lin [5];
   logic [LW-1:0] lg  [5];
   logic [PW-1:0] s_lin, tps_lin;
   wire           first = state_q == ST_LOG;
   wire [PW-1:0]  clut  = t0_q > r0_q ? t0_q - r0_q : '0;
   wire [PW:0]    cs_w  = {1'b0, clut} + {1'b0, s_lin};
   wire [PW-1:0]  cs    = cs_w[PW] ? '1 : cs_w[PW-1:0];
   wire [PW-1:0]  r0m   = r0_q > tps_lin ? r0_q - tps_lin : PW'(1);
   wire [PW-1:0]  tmn   = t0_q > nz_q ? t0_q - nz_q : '0;

   assign lin[0] = first ? t0_q : s_lin;
   assign lin[1] = first ? r0_q : cs;
   assign lin[2] = first ? r1_q : tps_lin;
   assign lin[3] = first ? nz_q : r0m;
   assign lin[4] = tmn;

   for (genvar k = 0; k < 5; k++) begin : g_log
      bqt_log2 #(.W(PW), .LW(LW)) u_log (
         .clk_i (clk_i),
         .x_i   (lin[k]),
         .y_o   (lg[k])
      );
   end

   // width normalised to Nyquist, 8 fraction bits
   wire [15:0]    w2    = 16'(w_q) * 16'(w_q);
   wire [26:0]    wprod = 27'(w2) * 27'(`BQT_WSQ_COEF);
   // weather power: lag1 times exp(pi^2 W^2 / 2)
   wire [LW:0]    log2s = {1'b0, lg[2]} + (LW+1)'(wprod[26:16]);
   wire [LW:0]    log2t = log2s + (LW+1)'(`BQT_LOG2_2PI);

   bqt_exp2 #(.W(PW), .LW(LW)) u_exp_s (
      .clk_i (clk_i),
      .y_i   (log2s),
      .x_o   (s_lin)
   );

   bqt_exp2 #(.W(PW), .LW(LW)) u_exp_t (
      .clk_i (clk_i),
      .y_i   (log2t),
      .x_o   (tps_lin)
   );

   // ------------------------------------------------------------
   // Metrics in dB, Q8.8
   // ------------------------------------------------------------
   wire three = ctrl_q[`BQT_CTRL_THREE];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snr_q   <= 16'h0;
         ccor2_q <= 16'h0;
         clutter_correction_q  <= 16'h0;
         sig_q   <= 16'h0;
      end else if (state_q == ST_EXP) begin
         snr_q   <= to_db(ldiff(lg[4], lg[3]));
         ccor2_q <= to_db(ldiff(lg[1], lg[0]));
      end else if (state_q == ST_DB) begin
         clutter_correction_q <= three ? to_db(ldiff(lg[0], lg[1])) : ccor2_q;
         sig_q  <= three ? to_db(ldiff(lg[2], lg[3]))
                         : snr_q + ccor2_q;
      end
   end

   // ------------------------------------------------------------
   // Qualification
   // ------------------------------------------------------------
   wire [3:0]     en   = ctrl_q[4:1];
   wire [15:0]    s2p  = 16'(thr_sqi_q) * 16'(sqi2_q[15:8]);
   wire [9:0]     s2s  = {2'b00, s2p[15:8]} +
                         {{2{sqi2_q[7]}}, sqi2_q[7:0]};
   // secondary coherence threshold, slope and offset
   wire [7:0]     thr2 = s2s[9] ? 8'h00 : s2s[8] ? 8'hff : s2s[7:0];
   wire [PW+7:0]  r1s  = {r1_q, 8'h00};
   wire [PW+7:0]  pr0  = (PW+8)'(thr_sqi_q) * (PW+8)'(r0_q);
   wire [PW+7:0]  pr02 = (PW+8)'(thr2) * (PW+8)'(r0_q);
   // strict tests, coherence as lag1 over lag0
   wire p_log  = ~en[0] | ($signed(snr_q) > $signed(thr_log_q));
   wire p_sqi  = ~en[1] | (r1s > pr0);
   wire p_sqi2 = ~en[1] | (r1s > pr02);
   wire p_clutter_correction = ~en[2] | ($signed(clutter_correction_q) > $signed(thr_clutter_correction_q));
   wire p_sig  = ~en[3] | ($signed(sig_q) > $signed(thr_sig_q));
   wire [3:0] idx_dop  = {p_sig, p_clutter_correction, p_sqi, p_log};
   wire [3:0] idx_refl = {p_sig, p_clutter_correction, p_sqi2, p_log};
   wire [4:0] pass_w = {comb_q[4][idx_refl], comb_q[3][idx_dop],
                        comb_q[2][idx_dop],  comb_q[1][idx_refl],
                        comb_q[0][idx_refl]};

   logic [15:0] oval_q [5];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pass_q    <= 5'h0;
         bin_cnt_q <= 16'h0;
         for (int k = 0; k < 5; k++) begin
            oval_q[k] <= `BQT_MARKER;
         end
      end else if (state_q == ST_DEC) begin
         pass_q    <= pass_w;
         bin_cnt_q <= bin_cnt_q + 16'h1;
         for (int k = 0; k < 5; k++) begin
            oval_q[k] <= pass_w[k] ? val_q[k] : `BQT_MARKER;
         end
      end
   end

   assign wb_ack_o                    = ack_q;
   assign wb_dat_o                    = dat_q;
   assign in_ready_o                  = ready_q;
   assign out_valid_o                 = ovalid_q;
   assign out_pass_o                  = pass_q;
   assign corrected_reflectivity_o    = oval_q[0];
   assign uncorrected_reflectivity_o  = oval_q[1];
   assign velocity_o                  = oval_q[2];
   assign width_value_o               = oval_q[3];
   assign differential_reflectivity_o = oval_q[4];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_bin_latency: assert property (
      acc |-> ##6 out_valid_o) else $error("bin result late");
   a_busy_stall: assert property (
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_pass_o))
      else $error("result dropped under stall");
   a_marker_fail: assert property (
      out_valid_o && !out_pass_o[2] |-> velocity_o == `BQT_MARKER)
      else $error("failed velocity not marked");
   a_pass_value: assert property (
      out_valid_o && out_pass_o[0] |-> corrected_reflectivity_o == val_q[0])
      else $error("passed value altered");
   a_clutter_correction_reject: assert property (
      state_q == ST_DEC && en[2] && $signed(clutter_correction_q) <= $signed(thr_clutter_correction_q)
      && comb_q[0] == `BQT_COMB_ZC_RST |=> !out_pass_o[0])
      else $error("clutter bin passed");
   a_snr_disable: assert property (
      state_q == ST_DEC && !en[0] && comb_q[1] == `BQT_COMB_ZU_RST
      |=> out_pass_o[1]) else $error("disabled test rejected");
   a_sig_mode: assert property (
      state_q == ST_DB && !three
      |=> sig_q == 16'($past(snr_q) + $past(ccor2_q)))
      else $error("two-lag weather ratio wrong");
   a_clutter_correction_mode: assert property (
      state_q == ST_DB && !three |=> clutter_correction_q == $past(ccor2_q))
      else $error("two-lag correction wrong");
   a_ack_pulse: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer malformed");
   a_defaults: assert property (
      $past(rst_i) |-> thr_log_q == `BQT_THR_LOG_RST &&
      thr_sig_q == `BQT_THR_SIG_RST) else $error("bad threshold reset");

   c_three_lag: cover property (state_q == ST_DEC && three);
   c_marked: cover property (out_valid_o && out_pass_o != 5'h1f);
   c_stall: cover property (out_valid_o && !out_ready_i);
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : bqt_qualifier

// ===== bqt_stream_model.sv
`timescale 1ns/1ps
// Upstream bin source and a downstream sink that stalls
module bqt_stream_model (
   input  wire logic   clk_i,
   input  wire logic   in_ready_i,
   input  wire logic   out_valid_i,
   output logic        in_valid_o,
   output logic        out_ready_o,
   output logic [23:0] total_o,
   output logic [23:0] lag0_o,
   output logic [23:0] lag1_o,
   output logic [23:0] noise_o
);
   int   wait_n = 0;
   logic rdy_n = 1'b0;
   initial begin
      in_valid_o = 1'b0;
      out_ready_o = 1'b0;
      {total_o, lag0_o, lag1_o, noise_o} = '0;
   end
   // Stall three cycles so results must stand
   always @(negedge clk_i) begin
      wait_n = (out_valid_i === 1'b1 && !rdy_n) ? wait_n + 1 : 0;
      rdy_n = wait_n > 2;
   end
   always @(posedge clk_i) out_ready_o <= rdy_n;
   task automatic send(input logic [23:0] t, a, b, n);
      int k;
      k = 0;
      @(posedge clk_i);
      in_valid_o <= 1'b1;
      {total_o, lag0_o, lag1_o, noise_o} <= {t, a, b, n};
      // Held until the edge at which ready is seen high
      do begin
         @(posedge clk_i);
         k++;
      end while (in_ready_i !== 1'b1 && k < 100);
      // Released lines invert so stale data cannot pass
      in_valid_o <= 1'b0;
      {total_o, lag0_o, lag1_o, noise_o} <= ~{t, a, b, n};
   endtask : send
endmodule : bqt_stream_model

// ===== tb_bin_quality_thresholding.sv
`timescale 1ns/1ps
`include "bqt_defines.svh"
module tb_bin_quality_thresholding;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, in_ready_o, out_valid_o, in_valid, out_ready;
   logic [23:0] tot, lz, lo, nz;
   logic [7:0]  wid = 8'h00;
   logic [15:0] vin [5] = '{default: 16'h0};
   logic [15:0] vout [5];
   logic [4:0]  out_pass_o;
   logic [15:0] comb_rst [5] = '{`BQT_COMB_ZC_RST, `BQT_COMB_ZU_RST,
      `BQT_COMB_VEL_RST, `BQT_COMB_WID_RST, `BQT_COMB_ZDR_RST};
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   bqt_qualifier #(.PW(24)) uut (
      .clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .in_valid_i(in_valid), .in_ready_o(in_ready_o),
      .unfiltered_total_power_i(tot), .lag_zero_power_i(lz),
      .lag_one_autocorr_i(lo), .noise_power_i(nz),
      .spectrum_width_i(wid),
      .corrected_reflectivity_i(vin[0]),
      .uncorrected_reflectivity_i(vin[1]),
      .velocity_i(vin[2]), .width_value_i(vin[3]),
      .differential_reflectivity_i(vin[4]),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready),
      .corrected_reflectivity_o(vout[0]),
      .uncorrected_reflectivity_o(vout[1]),
      .velocity_o(vout[2]), .width_value_o(vout[3]),
      .differential_reflectivity_o(vout[4]), .out_pass_o(out_pass_o));
   bqt_stream_model u_src (
      .clk_i(clk_i), .in_ready_i(in_ready_o), .out_valid_i(out_valid_o),
      .in_valid_o(in_valid), .out_ready_o(out_ready), .total_o(tot),
      .lag0_o(lz), .lag1_o(lo), .noise_o(nz));
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [31:0] e, q);
      comparisons++;
      if (q !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, q);
      end
   endtask : check
   // Classic cycle; ack and read data taken at the same rising edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      {cyc, we, adr, wdat} <= {1'b1, w, a, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         $display("BAD bus answer expected 1 seen 0");
      end
      {cyc, we} <= 2'b00;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check($sformatf("register %h", a), e, q);
   endtask : rd
   task automatic bin(input logic [23:0] t, a, b, n, input logic [4:0] ep);
      int k;
      k = 0;
      for (int i = 0; i < 5; i++) vin[i] <= 16'(16'h0111 * (i + 1) + t[19:4]);
      u_src.send(t, a, b, n);
      do begin
         @(negedge clk_i);
         k++;
      end while (!(out_valid_o === 1'b1 && out_ready === 1'b1) && k < 100);
      if (k >= 100) begin
         mismatches++;
         $display("BAD result handshake expected 1 seen 0");
      end
      check("pass flags", 32'(ep), 32'(out_pass_o));
      for (int i = 0; i < 5; i++)
         check($sformatf("value %0d", i), ep[i] ? vin[i] : 16'h0000, vout[i]);
      @(posedge clk_i);
   endtask : bin
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`BQT_ADR_CTRL, 32'h1e);
      rd(`BQT_ADR_THR_LOG, 32'h0080);
      rd(`BQT_ADR_THR_SQI, 32'h80);
      rd(`BQT_ADR_THR_CLUTTER_CORRECTION, 32'he700);
      rd(`BQT_ADR_THR_SIG, 32'h0a00);
      for (int i = 0; i < 5; i++) rd(8'(8'h18 + 4 * i), 32'(comb_rst[i]));
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0);
      bin(24'h100000, 24'h100000, 24'h0f0000, 24'h000100, 5'h1f);
      rd(`BQT_ADR_STATUS, 32'h001f_0001);
      bin(24'h400000, 24'h001000, 24'h000f00, 24'h000010, 5'h12);
      bin(24'h010000, 24'h010000, 24'h00f000, 24'h010000, 5'h04);
      wr(`BQT_ADR_CTRL, 32'h16);
      bin(24'h400000, 24'h001000, 24'h000f00, 24'h000010, 5'h1f);
      wr(`BQT_ADR_THR_LOG, 32'h3c00);
      bin(24'h400000, 24'h001000, 24'h000f00, 24'h000010, 5'h0c);
      wr(`BQT_ADR_CTRL, 32'h1e);
      wr(`BQT_ADR_THR_LOG, 32'h0080);
      wr(8'h1c, 32'hfffe);
      bin(24'h010000, 24'h010000, 24'h00f000, 24'h010000, 5'h06);
      wr(8'h1c, 32'hcccc);
      bin(24'h100000, 24'h100000, 24'h066666, 24'h000100, 5'h13);
      wr(`BQT_ADR_CTRL, 32'h1f);
      // Lower weather threshold for three-lag width qualification
      wr(`BQT_ADR_THR_SIG, 32'h0500);
      bin(24'h100000, 24'h100000, 24'h066666, 24'h000100, 5'h13);
      bin(24'h400000, 24'h001000, 24'h000f00, 24'h000010, 5'h12);
      // Full width lifts weather power enough to clear the clutter test
      wid <= 8'hff;
      bin(24'h400000, 24'h001000, 24'h000f00, 24'h000010, 5'h1f);
      close_out();
   end
endmodule : tb_bin_quality_thresholding
